// ==== core/tsb_pkg.sv ====
// Register map, field layout, flash-backed list and carriers of the tilt sensor
// register bank. Compiled ahead of the bank; no other assumptions.
package tsb_pkg;

  // Byte addresses of the low byte of each register
  localparam logic [6:0] TSB_FLASH_WRITE_COUNTER    = 7'h00;
  localparam logic [6:0] TSB_SUPPLY_VOLTAGE_OUT     = 7'h02;
  localparam logic [6:0] TSB_X_ACCEL_OUT            = 7'h04;
  localparam logic [6:0] TSB_Y_ACCEL_OUT            = 7'h06;
  localparam logic [6:0] TSB_AUXILIARY_INPUT_SAMPLE = 7'h08;
  localparam logic [6:0] TSB_TEMPERATURE_OUT        = 7'h0A;
  localparam logic [6:0] TSB_X_INCLINE_OUT          = 7'h0C;
  localparam logic [6:0] TSB_Y_INCLINE_OUT          = 7'h0E;
  localparam logic [6:0] TSB_VERTICAL_ROTATION_OUT  = 7'h10;
  localparam logic [6:0] TSB_X_ACCEL_OFFSET         = 7'h12;
  localparam logic [6:0] TSB_Y_ACCEL_OFFSET         = 7'h14;
  localparam logic [6:0] TSB_X_INCLINE_OFFSET       = 7'h16;
  localparam logic [6:0] TSB_Y_INCLINE_OFFSET       = 7'h18;
  localparam logic [6:0] TSB_ROTATION_OFFSET        = 7'h1A;
  localparam logic [6:0] TSB_ALARM1_THRESHOLD       = 7'h20;
  localparam logic [6:0] TSB_ALARM2_THRESHOLD       = 7'h22;
  localparam logic [6:0] TSB_ALARM1_PERIOD          = 7'h24;
  localparam logic [6:0] TSB_ALARM2_PERIOD          = 7'h26;
  localparam logic [6:0] TSB_ALARM_SOURCE_CONTROL   = 7'h28;
  localparam logic [6:0] TSB_AUXILIARY_OUTPUT_LEVEL = 7'h30;
  localparam logic [6:0] TSB_DIGITAL_IO_CONTROL     = 7'h32;
  localparam logic [6:0] TSB_DATA_READY_CONTROL     = 7'h34;
  localparam logic [6:0] TSB_SAMPLE_PERIOD          = 7'h36;
  localparam logic [6:0] TSB_AVERAGING_COUNT        = 7'h38;
  localparam logic [6:0] TSB_SLEEP_DURATION         = 7'h3A;
  localparam logic [6:0] TSB_SYSTEM_STATUS          = 7'h3C;
  localparam logic [6:0] TSB_SYSTEM_COMMAND         = 7'h3E;
  localparam logic [6:0] TSB_PRODUCT_IDENTIFIER     = 7'h4A;

  localparam int          TSB_WORDS         = 38;
  localparam int          TSB_OUT_N         = 8;
  localparam logic [4:0]  TSB_FRAME_BITS    = 5'h10;
  localparam int          TSB_CMD_SAVE_BIT  = 3;
  localparam logic [13:0] TSB_MASK_12       = 14'h0FFF;
  localparam logic [13:0] TSB_MASK_14       = 14'h3FFF;
  localparam logic [15:0] TSB_WORD_ZERO     = 16'h0000;

  // Flash-backed registers, in load and save order [RL9]
  localparam int          TSB_FB_N = 15;
  localparam logic [6:0]  TSB_FB_LIST [TSB_FB_N] = '{
    TSB_FLASH_WRITE_COUNTER, TSB_X_ACCEL_OFFSET, TSB_Y_ACCEL_OFFSET,
    TSB_X_INCLINE_OFFSET, TSB_Y_INCLINE_OFFSET, TSB_ROTATION_OFFSET,
    TSB_ALARM1_THRESHOLD, TSB_ALARM2_THRESHOLD, TSB_ALARM1_PERIOD,
    TSB_ALARM2_PERIOD, TSB_ALARM_SOURCE_CONTROL, TSB_SAMPLE_PERIOD,
    TSB_AVERAGING_COUNT, TSB_SLEEP_DURATION, TSB_PRODUCT_IDENTIFIER};

  typedef enum logic [1:0] {TSB_ST_LOAD, TSB_ST_IDLE, TSB_ST_SAVE} tsb_state_t;

  // val[0] supply, 1 x accel, 2 y accel, 3 aux, 4 temp, 5 x incl, 6 y incl, 7 rot
  typedef struct packed {
    logic                       valid;
    logic [TSB_OUT_N-1:0][13:0] val;
  } tsb_sample_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [5:0]  idx;
    logic [15:0] wdata;
  } tsb_flash_req_t;

  function automatic logic tsb_writable(logic [6:0] a);
    return a[6:1] inside {TSB_X_ACCEL_OFFSET[6:1], TSB_Y_ACCEL_OFFSET[6:1],
      TSB_X_INCLINE_OFFSET[6:1], TSB_Y_INCLINE_OFFSET[6:1], TSB_ROTATION_OFFSET[6:1],
      TSB_ALARM1_THRESHOLD[6:1], TSB_ALARM2_THRESHOLD[6:1], TSB_ALARM1_PERIOD[6:1],
      TSB_ALARM2_PERIOD[6:1], TSB_ALARM_SOURCE_CONTROL[6:1],
      TSB_AUXILIARY_OUTPUT_LEVEL[6:1], TSB_DIGITAL_IO_CONTROL[6:1],
      TSB_DATA_READY_CONTROL[6:1], TSB_SAMPLE_PERIOD[6:1], TSB_AVERAGING_COUNT[6:1],
      TSB_SLEEP_DURATION[6:1]};
  endfunction : tsb_writable

  function automatic logic tsb_readable(logic [6:0] a);
    return (tsb_writable(a) && a[6:1] != TSB_SLEEP_DURATION[6:1])
      || a[6:1] == TSB_FLASH_WRITE_COUNTER[6:1]
      || a[6:1] == TSB_PRODUCT_IDENTIFIER[6:1];
  endfunction : tsb_readable

endpackage : tsb_pkg

// ==== core/tsb_regbank.sv ====
// Tilt sensor register bank: 16-bit serial slave, working copy, flash load/save.
// Assumes a sensing core and a word-wide flash port on clk, and a mode 3 master
// that raises chip select between frames.
// Overview of operation
// [RL1] Registers 16 bits, bytes separately addressed
// [RL2] Master writes low byte, then high byte
// [RL3] Command trigger writes only the low byte
// [RL4] Command high-byte write aborts running operation
// [RL5] Write frame: flag, 7-bit address, data
// [RL6] Reset loads flash copy before register access
// [RL7] Serial writes touch working copy only
// [RL8] Command bit 3 saves all to flash
// [RL9] Only the listed registers are flash-backed
// [RL10] Output data only after a read frame
// [RL11] Output floats while chip select high
// [RL12] Output words: new flag, error, 14 bits
// [RL13] New flag clears on read, sets on sample
// [RL14] Error flag; status register holds causes
// [RL15] Write counter read-only, counts flash saves
// [RL16] Master avoids reserved bytes 0x1C to 0x1F
// [RL17] Supply output 14-bit unsigned
// [RL18] Auxiliary input output 12-bit unsigned
// [RL19] Temperature output 12-bit unsigned
// [RL20] Incline outputs 14-bit two's complement
// [RL21] Rotation output 14-bit two's complement
// [RL22] Acceleration offsets readable, writable, flash-backed
// [RL23] Sleep and command write-only, status read-only
// [RL24] Error bit set while status nonzero
// [RL25] Mode 3, MSB first, 16-bit words
// [RL26] Read: request frame, answer next frame
// [RL27] Frames bounded by chip select; partials ignored
// [RL28] Byte write leaves other byte unchanged
`timescale 1ns/100ps
module tsb_regbank
  import tsb_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         spi_sclk,
  input  wire logic                         spi_cs_b,
  input  wire logic                         spi_mosi,
  output wire logic                         spi_miso_o,
  output wire logic                         spi_miso_oe,
  input  wire tsb_sample_t                  sample_i,
  input  wire logic [15:0]                  status_i,
  output wire tsb_flash_req_t               flash_o,
  input  wire logic [15:0]                  flash_rdata_i,
  input  wire logic                         flash_ack_i,
  output wire logic [7:0]                   cmd_o,
  output wire logic                         cmd_pulse_o,
  output wire logic                         cmd_abort_o,
  output wire logic                         busy_o,
  output wire logic [TSB_WORDS-1:0][15:0]   cfg_o
);

  // Four-bit slot counter; word array must reach the identifier word
  if (TSB_FB_N > 16 || TSB_WORDS <= int'(TSB_PRODUCT_IDENTIFIER[6:1])) begin : g_fit_check
    $error("backed list or word array does not fit");
  end

  // Link side, clocked by the master's serial clock
  logic [4:0]  bit_cnt_reg;
  logic        done_reg;
  logic [15:0] rx_shift_reg;
  logic [3:0]  tx_idx_reg;
  logic        miso_reg;
  logic [15:0] tx_word_reg;

  // Chip select ends the frame; a stopped clock never has to
  always_ff @(posedge spi_sclk or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      bit_cnt_reg <= 5'h00;
      done_reg    <= 1'b0;
    end else if (bit_cnt_reg != TSB_FRAME_BITS) begin // [RL27]
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      done_reg    <= (bit_cnt_reg == TSB_FRAME_BITS - 5'h01);
    end
  end

  // Word freezes after 16 bits until the next frame
  always_ff @(posedge spi_sclk) begin
    if (bit_cnt_reg != TSB_FRAME_BITS) begin
      rx_shift_reg <= {rx_shift_reg[14:0], spi_mosi}; // [RL25]
    end
  end

  // Falling edge drives, master samples on the rising edge
  always_ff @(negedge spi_sclk or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      tx_idx_reg <= 4'h0;
      miso_reg   <= 1'b0;
    end else begin
      miso_reg   <= tx_word_reg[4'hF - tx_idx_reg]; // [RL25]
      tx_idx_reg <= tx_idx_reg + 4'h1;
    end
  end

  assign spi_miso_o  = miso_reg;
  assign spi_miso_oe = ~spi_cs_b; // [RL11]

  // Frame completion crosses as a level, then an edge
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_s3_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end else begin
      done_s1_reg <= done_reg;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end

  // Frame decode; rx word is stable while done is high
  tsb_state_t  state_reg;
  tsb_state_t  state_next;
  logic [3:0]  slot_reg;
  logic [3:0]  slot_next;
  logic [TSB_WORDS-1:0][15:0] sram_reg;
  logic [TSB_OUT_N-1:0][13:0] sample_reg;
  logic        nd_reg;
  logic [7:0]  cmd_reg;
  logic        cmd_pulse_reg;
  logic        cmd_abort_reg;

  wire         frame_ev  = done_s2_reg & ~done_s3_reg;
  wire         f_wr      = rx_shift_reg[15]; // [RL5]
  wire  [6:0]  f_addr    = rx_shift_reg[14:8];
  wire  [7:0]  f_data    = rx_shift_reg[7:0];
  wire  [5:0]  f_idx     = f_addr[6:1];
  wire         f_hi      = f_addr[0]; // [RL1]
  wire         ready     = (state_reg == TSB_ST_IDLE);
  wire         wr_ev     = frame_ev & f_wr & ready;
  wire         rd_ev     = frame_ev & ~f_wr;
  wire         is_cmd    = (f_idx == TSB_SYSTEM_COMMAND[6:1]);
  wire         wr_cfg    = wr_ev & tsb_writable(f_addr); // [RL22]
  wire         cmd_lo    = wr_ev & is_cmd & ~f_hi; // [RL3]
  wire         abort_hi  = frame_ev & f_wr & is_cmd & f_hi; // [RL4]
  wire         save_go   = cmd_lo & f_data[TSB_CMD_SAVE_BIT]; // [RL8]
  wire         is_out    = (f_idx >= TSB_SUPPLY_VOLTAGE_OUT[6:1])
                         && (f_idx <= TSB_VERTICAL_ROTATION_OUT[6:1]);
  wire         is_status = (f_idx == TSB_SYSTEM_STATUS[6:1]); // [RL14]
  wire         out_rd    = rd_ev & is_out & ready;

  // Output words; 12-bit channels read zero in the top two data bits
  wire  [2:0]  out_sel   = 3'(f_idx - 6'h01);
  wire         out_narrow = (f_idx == TSB_AUXILIARY_INPUT_SAMPLE[6:1])
                          || (f_idx == TSB_TEMPERATURE_OUT[6:1]); // [RL18] [RL19]
  wire  [13:0] out_val   = sample_reg[out_sel]
                         & (out_narrow ? TSB_MASK_12 : TSB_MASK_14); // [RL17] [RL20] [RL21]
  wire         fault_flag = (status_i != TSB_WORD_ZERO); // [RL24]
  wire  [15:0] out_word  = {nd_reg, fault_flag, out_val}; // [RL12]
  wire  [15:0] sram_word = sram_reg[f_idx];
  wire  [7:0]  hold_hi   = sram_word[15:8];
  wire  [7:0]  hold_lo   = sram_word[7:0];

  // Write-only and reserved addresses answer zero
  wire  [15:0] rd_word   = !ready               ? TSB_WORD_ZERO :
                           is_out               ? out_word      :
                           is_status            ? status_i      :
                           tsb_readable(f_addr) ? sram_word     : TSB_WORD_ZERO; // [RL23]

  // Flash walk over the backed list
  wire  [6:0]  fb_addr   = TSB_FB_LIST[slot_reg]; // [RL9]
  wire  [5:0]  fb_idx    = fb_addr[6:1];
  wire         last_slot = (slot_reg == 4'(TSB_FB_N - 1));
  wire         ld_ev     = (state_reg == TSB_ST_LOAD) & flash_ack_i;

  always_comb begin
    state_next = state_reg;
    slot_next  = slot_reg;
    unique case (state_reg)
      TSB_ST_LOAD: begin
        if (flash_ack_i) begin // [RL6]
          slot_next  = last_slot ? 4'h0 : slot_reg + 4'h1;
          state_next = last_slot ? TSB_ST_IDLE : TSB_ST_LOAD;
        end
      end
      TSB_ST_IDLE: begin
        if (save_go) begin // [RL8]
          slot_next  = 4'h0;
          state_next = TSB_ST_SAVE;
        end
      end
      TSB_ST_SAVE: begin
        if (abort_hi) begin // [RL4]
          slot_next  = 4'h0;
          state_next = TSB_ST_IDLE;
        end else if (flash_ack_i) begin
          slot_next  = last_slot ? 4'h0 : slot_reg + 4'h1;
          state_next = last_slot ? TSB_ST_IDLE : TSB_ST_SAVE;
        end
      end
      default: begin
        slot_next  = 4'h0;
        state_next = TSB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= TSB_ST_LOAD; // [RL6]
      slot_reg  <= 4'h0;
    end else begin
      state_reg <= state_next;
      slot_reg  <= slot_next;
    end
  end

  // Working copy; serial writes never reach flash by themselves
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sram_reg <= '0;
    end else if (ld_ev) begin
      sram_reg[fb_idx] <= flash_rdata_i; // [RL6]
    end else if (wr_cfg & ~f_hi) begin
      sram_reg[f_idx][7:0] <= f_data; // [RL7] [RL28]
    end else if (wr_cfg & f_hi) begin
      sram_reg[f_idx][15:8] <= f_data; // [RL28]
    end else if (save_go) begin
      // Counted at the start so the saved copy carries it
      sram_reg[0] <= sram_reg[0] + 16'h0001; // [RL15]
    end
  end

  // Set wins over the read clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nd_reg <= 1'b0;
    end else begin
      nd_reg <= sample_i.valid | (nd_reg & ~out_rd); // [RL13]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sample_reg <= '0;
    end else if (sample_i.valid) begin
      sample_reg <= sample_i.val;
    end
  end

  // Answer is ready long before the master's next frame; the link side
  // reads it unsynchronised, safe only while cs stays high between frames
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_word_reg <= TSB_WORD_ZERO;
    end else if (frame_ev) begin
      tx_word_reg <= rd_ev ? rd_word : TSB_WORD_ZERO; // [RL10] [RL26]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_reg       <= 8'h00;
      cmd_pulse_reg <= 1'b0;
      cmd_abort_reg <= 1'b0;
    end else begin
      cmd_pulse_reg <= cmd_lo;
      cmd_abort_reg <= abort_hi; // [RL4]
      if (cmd_lo) begin
        cmd_reg <= f_data;
      end
    end
  end

  // Flash is written only while saving
  assign flash_o.req   = (state_reg != TSB_ST_IDLE);
  assign flash_o.we    = (state_reg == TSB_ST_SAVE); // [RL7]
  assign flash_o.idx   = fb_idx;
  assign flash_o.wdata = sram_reg[fb_idx];
  assign cmd_o         = cmd_reg;
  assign cmd_pulse_o   = cmd_pulse_reg;
  assign cmd_abort_o   = cmd_abort_reg;
  assign busy_o        = ~ready;
  assign cfg_o         = sram_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_load_after_reset: assert property ( // [RL6]
    $rose(rst_b) |-> state_reg == TSB_ST_LOAD)
    else $error("bank not loading after reset");
  a_nd_sets: assert property ( // [RL13]
    sample_i.valid |=> nd_reg)
    else $error("new sample flag not set");
  a_nd_clears_read: assert property ( // [RL13]
    out_rd && !sample_i.valid |=> !nd_reg)
    else $error("new sample flag not cleared by read");
  a_fault_in_word: assert property ( // [RL24]
    out_rd |=> tx_word_reg[14] == ($past(status_i) != TSB_WORD_ZERO))
    else $error("fault flag does not follow status");
  a_byte_write_keeps: assert property ( // [RL28]
    wr_cfg && !f_hi |=> sram_reg[$past(f_idx)][15:8] == $past(hold_hi)
      && sram_reg[$past(f_idx)][7:0] == $past(f_data))
    else $error("low byte write disturbed high byte");
  a_hi_write_keeps: assert property ( // [RL1]
    wr_cfg && f_hi |=> sram_reg[$past(f_idx)][7:0] == $past(hold_lo))
    else $error("high byte write disturbed low byte");
  a_save_counts: assert property ( // [RL15]
    save_go |=> sram_reg[0] == $past(sram_reg[0]) + 16'h0001 ##0 flash_o.we)
    else $error("save not counted or not started");
  a_save_abort: assert property ( // [RL4]
    state_reg == TSB_ST_SAVE && abort_hi |=> !flash_o.req ##1 cmd_abort_o == 1'b0)
    else $error("high byte command did not abort save");
  a_no_flash_write: assert property ( // [RL7]
    wr_cfg |=> !flash_o.we)
    else $error("serial write reached flash");
  a_write_no_data: assert property ( // [RL10]
    frame_ev && f_wr |=> tx_word_reg == TSB_WORD_ZERO)
    else $error("data after write frame");
  a_wo_reads_zero: assert property ( // [RL23]
    rd_ev && f_idx == TSB_SLEEP_DURATION[6:1] |=> tx_word_reg == TSB_WORD_ZERO)
    else $error("write-only register read back");
  a_miso_floats: assert property ( // [RL11]
    spi_cs_b |-> !spi_miso_oe)
    else $error("output driven without chip select");
  a_cmd_pulse: assert property ( // [RL3]
    cmd_lo |=> cmd_pulse_o && cmd_o == $past(f_data))
    else $error("command pulse or byte missing");
  a_status_read: assert property ( // [RL14]
    rd_ev && is_status && ready |=> tx_word_reg == $past(status_i))
    else $error("status word not returned");
  a_narrow_top: assert property ( // [RL18] [RL19]
    out_rd && out_narrow |=> tx_word_reg[13:12] == 2'b00)
    else $error("12-bit channel top bits not zero");
  a_out_value: assert property ( // [RL17] [RL20] [RL21]
    out_rd && !out_narrow |=> tx_word_reg[13:0] == $past(sample_reg[out_sel]))
    else $error("14-bit channel value wrong");
  a_nd_in_word: assert property ( // [RL12]
    out_rd |=> tx_word_reg[15] == $past(nd_reg))
    else $error("new sample flag not in top bit");
  a_busy_reads_zero: assert property ( // [RL6]
    rd_ev && !ready |=> tx_word_reg == TSB_WORD_ZERO)
    else $error("register read answered while busy");
  a_busy_write_ignored: assert property ( // [RL6]
    frame_ev && f_wr && state_reg == TSB_ST_SAVE |=> $stable(sram_reg))
    else $error("write landed while saving");
  a_load_stores: assert property ( // [RL6]
    ld_ev |=> sram_reg[$past(fb_idx)] == $past(flash_rdata_i))
    else $error("loaded word not stored");
  a_load_ends: assert property ( // [RL6]
    ld_ev && last_slot |=> ready)
    else $error("load did not end after last word");
  a_save_ends: assert property ( // [RL8]
    state_reg == TSB_ST_SAVE && flash_ack_i && last_slot |=> ready)
    else $error("save did not end after last word");
  a_save_steps: assert property ( // [RL8]
    state_reg == TSB_ST_SAVE && flash_ack_i && !last_slot && !abort_hi
      |=> slot_reg == $past(slot_reg) + 4'h1)
    else $error("save skipped a word");
  a_counter_ro: assert property ( // [RL15]
    wr_ev && f_idx == TSB_FLASH_WRITE_COUNTER[6:1] |=> $stable(sram_reg[0]))
    else $error("write counter changed by a write");
  a_abort_pulse: assert property ( // [RL4]
    abort_hi |=> cmd_abort_o)
    else $error("abort pulse missing");

  c_load_done:  cover property (state_reg == TSB_ST_LOAD ##1 state_reg == TSB_ST_IDLE);
  c_save_done:  cover property (state_reg == TSB_ST_SAVE && last_slot && flash_ack_i);
  c_save_abort: cover property (state_reg == TSB_ST_SAVE && abort_hi);
  c_out_read:   cover property (out_rd && nd_reg);
  c_busy_read:  cover property (rd_ev && !ready);

endmodule : tsb_regbank

// ==== bench/tsb_spi_master.sv ====
// Serial master model: mode 3 frames on its own 32 ns clock, MSB first.
// Assumes the bench calls frame() and waits on rx_ev for each full reply.
`timescale 1ns/100ps
module tsb_spi_master (
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_mosi,
  input  wire logic miso
);
  logic [15:0] rx_word;
  event        rx_ev;

  initial begin
    spi_sclk = 1'b1;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end

  // Frames shorter than 16 bits are cut on purpose and give no reply
  task automatic frame(input logic [15:0] w, input int n);
    #($urandom_range(31, 1));
    spi_cs_b = 1'b0;
    #16;
    for (int i = 15; i > 15 - n; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = w[i];
      #16;
      spi_sclk = 1'b1;
      rx_word[i] = miso;
      #16;
    end
    spi_cs_b = 1'b1;
    spi_mosi = ~spi_mosi;
    // Gap well over the slave's minimum cs-high time
    #128;
    if (n == 16)
      ->rx_ev;
  endtask : frame
endmodule : tsb_spi_master

// ==== bench/tsb_regbank_bench.sv ====
// Bench for the tilt sensor register bank with master, flash and core stand-ins.
// Assumes tsb_pkg and tsb_regbank are compiled first.
`timescale 1ns/100ps
module tsb_regbank_bench;
  import tsb_pkg::*;
  logic                            clk;
  logic                            rst_b;
  wire logic                       spi_sclk, spi_cs_b, spi_mosi, spi_miso_o, spi_miso_oe;
  wire logic                       miso_w;
  tsb_sample_t                     sample;
  logic [15:0]                     status;
  wire tsb_flash_req_t             flash;
  logic [15:0]                     fl_rdata;
  logic                            fl_ack;
  logic                            fl_go;
  wire logic [7:0]                 cmd;
  wire logic                       cmd_pulse, cmd_abort, busy;
  wire logic [TSB_WORDS-1:0][15:0] cfg;
  logic [15:0]                     fmem [TSB_WORDS];
  logic [15:0]                     cfg_m [TSB_WORDS];
  logic [16:0]                     exp_q [$];
  logic [16:0]                     nxt, got_e;
  logic                            nd_m;
  int fails, tests_run, cyc, fl_lat, fl_cnt, n_fw, n_pulse, n_abort;

  assign miso_w = spi_miso_oe ? spi_miso_o : 1'bz;

  tsb_regbank tsb_regbank_inst (
    .clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .sample_i(sample), .status_i(status), .flash_o(flash), .flash_rdata_i(fl_rdata),
    .flash_ack_i(fl_ack), .cmd_o(cmd), .cmd_pulse_o(cmd_pulse),
    .cmd_abort_o(cmd_abort), .busy_o(busy), .cfg_o(cfg));

  tsb_spi_master tsb_spi_master_inst (
    .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .miso(miso_w));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Flash stand-in; a dropped request restarts its latency count
  always @(posedge clk) begin
    fl_cnt = (flash.req === 1'b1 && fl_ack !== 1'b1) ? fl_cnt + 1 : 0;
    fl_go = (fl_cnt >= fl_lat);
    fl_ack <= #1 fl_go;
    fl_rdata <= #1 fl_go ? fmem[flash.idx] : ~fl_rdata;
    if (fl_go) begin
      fl_cnt = 0;
      if (flash.we) begin
        fmem[flash.idx] = flash.wdata;
        n_fw++;
      end
    end
    if (cmd_pulse === 1'b1)
      n_pulse++;
    if (cmd_abort === 1'b1)
      n_abort++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  initial forever begin
    @(tsb_spi_master_inst.rx_ev);
    got_e = exp_q.pop_front();
    if (got_e[16])
      check(tsb_spi_master_inst.rx_word, got_e[15:0], "reply");
  end

  task automatic check(input logic [15:0] got, input logic [15:0] e, input string what);
    tests_run++;
    if (got !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, e);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Reply of this frame is checked during the following one
  task automatic xfer(input logic [15:0] w, input logic [15:0] rep);
    exp_q.push_back(nxt);
    tsb_spi_master_inst.frame(w, 16);
    nxt = {1'b1, rep};
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer({1'b1, a, d}, 16'h0000);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    xfer({1'b0, a, 8'h00}, e);
  endtask : rd

  task automatic wr_word(input logic [6:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    cfg_m[a[6:1]][7:0] = v[7:0];
    rd(a, cfg_m[a[6:1]]);
    wr(a | 7'h01, v[15:8]);
    cfg_m[a[6:1]][15:8] = v[15:8];
    rd(a | 7'h01, cfg_m[a[6:1]]);
    check(cfg[a[6:1]], cfg_m[a[6:1]], "working copy");
  endtask : wr_word

  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge clk);
    check({15'h0000, busy}, 16'h0000, "busy");
  endtask : wait_idle

  task automatic sample_upd();
    @(posedge clk);
    #1;
    for (int i = 0; i < TSB_OUT_N; i++)
      sample.val[i] = 14'($urandom);
    sample.valid = 1'b1;
    @(posedge clk);
    #1 sample.valid = 1'b0;
    nd_m = 1'b1;
  endtask : sample_upd

  function automatic logic [15:0] out_exp(input int i);
    logic [13:0] m;
    m = (i == 3 || i == 4) ? TSB_MASK_12 : TSB_MASK_14;
    out_exp = {nd_m, status != 16'h0000, sample.val[i] & m};
    nd_m = 1'b0;
  endfunction : out_exp

  initial begin
    void'($urandom(32'h2FB0D0D8));
    {rst_b, fl_ack, fl_rdata, status, sample, nxt, nd_m} = '0;
    {fails, tests_run, cyc, fl_cnt, n_fw, n_pulse, n_abort} = '0;
    fl_lat = 3;
    for (int i = 0; i < TSB_WORDS; i++) begin
      fmem[i] = 16'($urandom);
      cfg_m[i] = 16'h0000;
    end
    for (int i = 0; i < TSB_FB_N; i++)
      cfg_m[TSB_FB_LIST[i][6:1]] = fmem[TSB_FB_LIST[i][6:1]];
    repeat (8) @(posedge clk);
    check({15'h0000, busy}, 16'h0001, "busy in reset");
    #1 rst_b = 1'b1;
    wait_idle();
    for (int i = 0; i < TSB_FB_N; i++)
      check(cfg[TSB_FB_LIST[i][6:1]], cfg_m[TSB_FB_LIST[i][6:1]], "load");
    check({15'h0000, spi_miso_oe}, 16'h0000, "idle enable");
    rd(TSB_FLASH_WRITE_COUNTER, cfg_m[0]);
    rd(TSB_PRODUCT_IDENTIFIER, cfg_m[TSB_PRODUCT_IDENTIFIER[6:1]]);
    wr_word(TSB_X_ACCEL_OFFSET, 16'($urandom));
    wr_word(TSB_SAMPLE_PERIOD, 16'($urandom));
    check(16'(n_fw), 16'h0000, "flash untouched");
    wr(TSB_FLASH_WRITE_COUNTER, 8'hA5);
    rd(TSB_FLASH_WRITE_COUNTER, cfg_m[0]);
    wr(TSB_SLEEP_DURATION, 8'h5A);
    cfg_m[TSB_SLEEP_DURATION[6:1]][7:0] = 8'h5A;
    rd(TSB_SLEEP_DURATION, 16'h0000);
    rd(TSB_SYSTEM_COMMAND, 16'h0000);
    rd(7'h1C, 16'h0000);
    @(posedge clk) #1 status = 16'h0204;
    rd(TSB_SYSTEM_STATUS, status);
    @(posedge clk) #1 status = 16'h0000;
    sample_upd();
    for (int i = 0; i < TSB_OUT_N; i++)
      rd(7'(2 * i + 2), out_exp(i));
    @(posedge clk) #1 status = 16'h0010;
    sample_upd();
    rd(TSB_VERTICAL_ROTATION_OUT, out_exp(7));
    rd(TSB_TEMPERATURE_OUT, out_exp(4));
    tsb_spi_master_inst.frame({1'b1, TSB_SAMPLE_PERIOD, 8'hFF}, 8);
    rd(TSB_SAMPLE_PERIOD, cfg_m[TSB_SAMPLE_PERIOD[6:1]]);
    wr(TSB_SYSTEM_COMMAND, 8'h08);
    check({8'h00, cmd}, 16'h0008, "command");
    check(16'(n_pulse), 16'h0001, "command pulse");
    wait_idle();
    cfg_m[0] = cfg_m[0] + 16'h0001;
    for (int i = 0; i < TSB_FB_N; i++)
      check(fmem[TSB_FB_LIST[i][6:1]], cfg_m[TSB_FB_LIST[i][6:1]], "saved");
    check(16'(n_fw), 16'(TSB_FB_N), "saved words");
    rd(TSB_FLASH_WRITE_COUNTER, cfg_m[0]);
    fl_lat = 40;
    wr(TSB_SYSTEM_COMMAND, 8'h08);
    cfg_m[0] = cfg_m[0] + 16'h0001;
    rd(TSB_FLASH_WRITE_COUNTER, 16'h0000);
    wr(TSB_SYSTEM_COMMAND | 7'h01, 8'h00);
    check(16'(n_abort), 16'h0001, "abort pulse");
    repeat (4) @(posedge clk);
    check({15'h0000, busy}, 16'h0000, "aborted save");
    fl_lat = 3;
    rd(TSB_FLASH_WRITE_COUNTER, cfg_m[0]);
    rd(TSB_FLASH_WRITE_COUNTER, cfg_m[0]);
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule : tsb_regbank_bench
